// *** verification/iws_host_model.sv ***
// behavioural bus master driving the serial clock and data lines
`timescale 1ns/1ps
`default_nettype none
module iws_host_model (
  input wire logic i_dev_sda,
  input wire logic i_dev_oe_b,
  output logic o_scl,
  output logic o_sda
);
  localparam time Q = 320;
  logic sda_drv = 1'b1;
  initial o_scl = 1'b1; // clock always driven
  // pull-up wins only when both sides let go
  assign o_sda = sda_drv & (i_dev_oe_b | i_dev_sda);
  task automatic wake(input int ns_low);
    sda_drv = 1'b0;
    #(ns_low) sda_drv = 1'b1;
  endtask
  task automatic start();
    #13 sda_drv = 1'b1;
    #Q o_scl = 1'b1;
    #Q sda_drv = 1'b0;
    #Q o_scl = 1'b0;
    #Q;
  endtask
  task automatic stop();
    sda_drv = 1'b0;
    #Q o_scl = 1'b1;
    #Q sda_drv = 1'b1;
    #Q;
  endtask
  task automatic send(input logic [7:0] b, input int n, output logic ack);
    ack = 1'b0;
    for (int i = 7; i > 7 - n; i--) begin
      sda_drv = b[i]; // msb first, only while clock low
      #Q o_scl = 1'b1;
      #(2*Q) o_scl = 1'b0;
      #Q;
    end
    if (n == 8) begin
      sda_drv = 1'b1;
      #Q o_scl = 1'b1;
      #Q ack = !o_sda;
      #Q o_scl = 1'b0;
      #Q;
    end
  endtask
endmodule
`default_nettype wire

// *** verification/iws_slave_props.sv ***
// assertion checker for the wake slave, bound to its ports
`timescale 1ns/1ps
`default_nettype none
module iws_slave_props
  import iws_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RST_B,
  input wire logic I_SCL,
  input wire logic I_SDA,
  input wire logic O_SDA,
  input wire logic O_SDA_OE_B,
  input wire logic [7:0] I_ADDR_CFG,
  input wire logic I_EXEC_DONE,
  input wire logic O_TTL_EN,
  input wire logic O_AWAKE,
  input wire logic O_BUSY,
  input wire logic O_CMD_VALID,
  input wire logic O_IDLE_REQ,
  input wire logic O_SLEEP_REQ,
  input wire logic O_WDT_RESET
);
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_B);
  int low_run;
  logic long_low;
  // small slack for the pin synchroniser lag
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      low_run <= 0;
      long_low <= 1'b0;
    end else begin
      low_run <= I_SDA ? 0 : low_run + 1;
      if (low_run >= WAKE_LOW_CYC - 4)
        long_low <= 1'b1;
      else if (O_AWAKE)
        long_low <= 1'b0;
    end
  end
  chk_sda_zero: assert property (O_SDA == 1'b0)
    else $error("data drive value not zero");
  chk_ttl_copy: assert property ($past(I_RST_B) |-> O_TTL_EN == $past(I_ADDR_CFG[TTL_EN_BIT]))
    else $error("threshold select not a copy of config bit");
  chk_sleep_quiet: assert property (O_SLEEP_REQ && $past(O_SLEEP_REQ) |-> O_SDA_OE_B)
    else $error("data line driven while asleep");
  chk_idle_quiet: assert property (O_IDLE_REQ && $past(O_IDLE_REQ) |-> O_SDA_OE_B)
    else $error("data line driven while idle");
  chk_oe_clock_low: assert property ($changed(O_SDA_OE_B) |-> !I_SCL)
    else $error("data drive changed with clock high");
  chk_busy_cause: assert property ($rose(O_BUSY) |-> $past(O_CMD_VALID))
    else $error("busy without a complete command");
  chk_busy_ends: assert property (O_BUSY && I_EXEC_DONE |-> ##[1:3] !O_BUSY)
    else $error("busy not ended by execution done");
  chk_cmd_pulse: assert property (O_CMD_VALID |=> O_BUSY && !O_CMD_VALID)
    else $error("command pulse not followed by busy");
  chk_wdt_sleep: assert property (O_WDT_RESET |-> ##[0:2] (O_SLEEP_REQ && !O_AWAKE))
    else $error("watchdog did not force sleep");
  chk_wake_cause: assert property ($rose(O_AWAKE) |-> long_low)
    else $error("awake without a long data low");
  cover property ($rose(O_BUSY));
  cover property ($rose(O_AWAKE));
  cover property (O_WDT_RESET);
endmodule
bind iws_slave iws_slave_props i_iws_slave_props (.I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_SCL(I_SCL),
  .I_SDA(I_SDA), .O_SDA(O_SDA), .O_SDA_OE_B(O_SDA_OE_B), .I_ADDR_CFG(I_ADDR_CFG), .I_EXEC_DONE(I_EXEC_DONE),
  .O_TTL_EN(O_TTL_EN), .O_AWAKE(O_AWAKE), .O_BUSY(O_BUSY), .O_CMD_VALID(O_CMD_VALID),
  .O_IDLE_REQ(O_IDLE_REQ), .O_SLEEP_REQ(O_SLEEP_REQ), .O_WDT_RESET(O_WDT_RESET));
`default_nettype wire

// *** verification/iws_slave_test.sv ***
// self-checking bench for the wake slave
`timescale 1ns/1ps
`default_nettype none
module iws_slave_test;
  import iws_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic done_in = 1'b0;
  logic ack;
  logic [7:0] cfg = 8'hc8;
  wire scl;
  wire sda;
  logic o_sda, oe_b, ttl, awake, busy, cmd_v, byte_v, ptr, idle, sleep, wdt;
  logic [7:0] cnt, bdat;
  int mismatches = 0, checks_done = 0, n_cmd = 0, n_byte = 0, n_ptr = 0, n_wdt = 0, cyc = 0;
  iws_slave #(.WATCHDOG_CYCLES(5000), .READY_CYCLES(200), .SCL_EN_CYCLES(100)) i_iws_slave (
    .I_CLK(clk), .I_RST_B(rst_b), .I_SCL(scl), .I_SDA(sda), .O_SDA(o_sda), .O_SDA_OE_B(oe_b),
    .I_ADDR_CFG(cfg), .I_EXEC_DONE(done_in), .O_TTL_EN(ttl), .O_AWAKE(awake), .O_BUSY(busy),
    .O_CMD_VALID(cmd_v), .O_CMD_COUNT(cnt), .O_BYTE_VALID(byte_v), .O_BYTE_DATA(bdat),
    .O_PTR_RESET(ptr), .O_IDLE_REQ(idle), .O_SLEEP_REQ(sleep), .O_WDT_RESET(wdt));
  iws_host_model i_iws_host_model (.i_dev_sda(o_sda), .i_dev_oe_b(oe_b), .o_scl(scl), .o_sda(sda));
  initial forever #20 clk = ~clk;
  task automatic test_done();
    if (mismatches == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // pulses are counted so that no one-cycle output is missed
  always @(posedge clk) begin
    n_cmd <= n_cmd + int'(cmd_v);
    n_byte <= n_byte + int'(byte_v);
    n_ptr <= n_ptr + int'(ptr);
    n_wdt <= n_wdt + int'(wdt);
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      mismatches++;
      test_done();
    end
  end
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pkt(input logic [7:0] b[$], input logic [7:0] ea, input bit stp);
    i_iws_host_model.start();
    foreach (b[i]) begin
      i_iws_host_model.send(b[i], 8, ack);
      check("ack", ea[i], ack);
    end
    if (stp)
      i_iws_host_model.stop();
  endtask
  task automatic wake();
    i_iws_host_model.wake(70000);
    wt(250);
    check("awake", 1, awake);
  endtask
  task automatic exec_done();
    @(posedge clk) done_in <= 1'b1;
    @(posedge clk) done_in <= 1'b0;
    wt(5);
    check("busy", 0, busy);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    wt(3);
    check("sleep", 1, sleep);
    check("ttl", 1, ttl);
    pkt({8'hc8}, 8'h00, 1);
    i_iws_host_model.wake(40000);
    wt(300);
    check("awake", 0, awake);
    wake();
    pkt({8'hca}, 8'h00, 1);
    pkt({8'hc9}, 8'h00, 1);
    pkt({8'h48}, 8'h00, 1);
    pkt({8'hc8, FN_RESET}, 8'h03, 1);
    wt(10);
    check("ptr", 1, n_ptr);
    pkt({8'hc8, FN_COMMAND, 8'h03, 8'h5a, 8'ha5}, 8'h1f, 0);
    wt(5);
    check("cmd", 1, n_cmd);
    check("count", 8'h03, cnt);
    check("bytes", 3, n_byte);
    check("data", 8'ha5, bdat);
    check("busy", 1, busy);
    i_iws_host_model.send(8'h77, 8, ack);
    check("ack", 0, ack);
    i_iws_host_model.stop();
    pkt({8'hc8}, 8'h00, 1);
    exec_done();
    pkt({8'hc8, FN_COMMAND, 8'h02, 8'h11}, 8'h0f, 1);
    wt(5);
    check("cmd", 2, n_cmd);
    exec_done();
    i_iws_host_model.start();
    i_iws_host_model.send(8'hc8, 4, ack);
    pkt({8'hc8, FN_RESET}, 8'h03, 1);
    wt(10);
    check("ptr", 2, n_ptr);
    wake();
    check("cmd", 2, n_cmd);
    pkt({8'hc8, FN_IDLE}, 8'h01, 1);
    wt(10);
    check("idle", 1, idle);
    pkt({8'hc8}, 8'h00, 1);
    wake();
    pkt({8'hc8, FN_SLEEP}, 8'h01, 1);
    wt(10);
    check("sleep", 1, sleep);
    wake();
    pkt({8'hc8}, 8'h01, 0);
    wt(5200);
    check("wdt", 1, n_wdt > 0);
    check("sleep", 1, sleep);
    test_done();
  end
endmodule
`default_nettype wire

// *** verilog/iws_pkg.sv ***
// constants for the two-wire wake slave interface
package iws_pkg;
  localparam int CLK_HZ = 25000000;
  localparam int WAKE_LOW_TIME_NS = 60000;
  localparam int WAKE_TO_READY_DELAY_US = 2500;
  localparam int WAKE_LOW_CYC = (WAKE_LOW_TIME_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int WAKE_READY_CYC = WAKE_TO_READY_DELAY_US * (CLK_HZ / 1000000);
  localparam int SCL_ENABLE_CYC = WAKE_READY_CYC / 2;
  localparam int WATCHDOG_MS = 1300;
  localparam int WATCHDOG_CYC = WATCHDOG_MS * (CLK_HZ / 1000);
  localparam int BYTE_BITS = 8;
  localparam int ADDR_HI_BIT = 7;
  localparam int ADDR_LO_BIT = 1;
  localparam int TTL_EN_BIT = 3;
  localparam logic [7:0] FN_RESET = 8'h00;
  localparam logic [7:0] FN_SLEEP = 8'h01;
  localparam logic [7:0] FN_IDLE = 8'h02;
  localparam logic [7:0] FN_COMMAND = 8'h03;
  localparam logic [7:0] ADDR_RESET = 8'hc8;
  typedef enum logic [5:0] {
    PW_SLEEP = 6'h01,
    PW_WAKELOW = 6'h02,
    PW_WARMUP = 6'h04,
    PW_AWAKE = 6'h08,
    PW_BUSY = 6'h10,
    PW_IDLE = 6'h20
  } iws_power_type;
  typedef enum logic [3:0] {
    BS_WAIT = 4'h1,
    BS_ADDR = 4'h2,
    BS_FUNC = 4'h4,
    BS_DATA = 4'h8
  } iws_bus_type;
endpackage

// *** verilog/iws_slave.sv ***
// two-wire target with data-line wake, address match and command hand-over
`timescale 1ns/1ps
`default_nettype none
module iws_slave
  import iws_pkg::*;
#(
  parameter int WATCHDOG_CYCLES = WATCHDOG_CYC,
  parameter int READY_CYCLES = WAKE_READY_CYC,
  parameter int SCL_EN_CYCLES = SCL_ENABLE_CYC,
  parameter int BUF_DEPTH = 128
) (
  input wire logic I_CLK,
  input wire logic I_RST_B,
  input wire logic I_SCL,
  input wire logic I_SDA,
  output logic O_SDA,
  output logic O_SDA_OE_B,
  input wire logic [7:0] I_ADDR_CFG,
  input wire logic I_EXEC_DONE,
  output logic O_TTL_EN,
  output logic O_AWAKE,
  output logic O_BUSY,
  output logic O_CMD_VALID,
  output logic [7:0] O_CMD_COUNT,
  output logic O_BYTE_VALID,
  output logic [7:0] O_BYTE_DATA,
  output logic O_PTR_RESET,
  output logic O_IDLE_REQ,
  output logic O_SLEEP_REQ,
  output logic O_WDT_RESET
);
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic scl_d_reg;
  logic sda_d_reg;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic scl_en;
  iws_power_type pw_reg;
  iws_bus_type bs_reg;
  logic [31:0] tmr_reg;
  logic [31:0] wdt_reg;
  logic [3:0] bit_reg;
  logic [7:0] sh_reg;
  logic ack_reg;
  logic slot_reg;
  logic from_idle_reg;
  logic [7:0] count_reg;
  logic [7:0] got_reg;
  logic full_go;

  // two synchroniser flops per pin plus a delay flop; the second stage and the delay flop are read
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], I_SCL};
      sda_sync_reg <= {sda_sync_reg[0], I_SDA};
      scl_d_reg <= scl_sync_reg[1];
      sda_d_reg <= sda_sync_reg[1];
    end
  end

  // clock sensing only once warm-up passes its midpoint
  assign scl_en = (pw_reg == PW_AWAKE) || (pw_reg == PW_BUSY) ||
                  ((pw_reg == PW_WARMUP) && (tmr_reg >= 32'(SCL_EN_CYCLES)));
  assign scl_rise = scl_en && scl_sync_reg[1] && !scl_d_reg;
  assign scl_fall = scl_en && !scl_sync_reg[1] && scl_d_reg;
  assign start_det = scl_en && scl_sync_reg[1] && scl_d_reg && sda_d_reg && !sda_sync_reg[1];
  assign stop_det = scl_en && scl_sync_reg[1] && scl_d_reg && !sda_d_reg && sda_sync_reg[1];
  assign full_go = (bs_reg == BS_DATA) && (count_reg != 8'h00) && (got_reg >= count_reg);

  // power state: sleep, idle, wake detection, warm-up, awake, busy
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      pw_reg <= PW_SLEEP;
      tmr_reg <= 32'h0;
      from_idle_reg <= 1'b0;
    end else if (wdt_reg >= 32'(WATCHDOG_CYCLES)) begin
      pw_reg <= PW_SLEEP;
      tmr_reg <= 32'h0;
    end else begin
      unique case (pw_reg)
        PW_SLEEP, PW_IDLE: begin
          // only a low data line is watched here
          if (!sda_sync_reg[1]) begin
            pw_reg <= PW_WAKELOW;
            from_idle_reg <= (pw_reg == PW_IDLE);
          end
          tmr_reg <= 32'h0;
        end
        PW_WAKELOW: begin
          if (sda_sync_reg[1]) begin
            // short lows such as a stop must not turn idle into sleep
            pw_reg <= from_idle_reg ? PW_IDLE : PW_SLEEP;
            tmr_reg <= 32'h0;
          end else if (tmr_reg >= 32'(WAKE_LOW_CYC)) begin
            pw_reg <= PW_WARMUP;
            tmr_reg <= 32'h0;
          end else begin
            tmr_reg <= tmr_reg + 32'h1;
          end
        end
        PW_WARMUP: begin
          if (tmr_reg >= 32'(READY_CYCLES)) begin
            pw_reg <= PW_AWAKE;
          end else begin
            tmr_reg <= tmr_reg + 32'h1;
          end
        end
        PW_AWAKE: begin
          // a held-low data line here is not a wake: no state change
          tmr_reg <= 32'h0;
          if (bs_reg == BS_FUNC && bit_reg == 4'd8 && scl_rise) begin
            if (sh_reg == FN_SLEEP) begin
              pw_reg <= PW_SLEEP;
            end else if (sh_reg == FN_IDLE) begin
              pw_reg <= PW_IDLE;
            end
          end else if (full_go && (stop_det || bit_reg == 4'd0)) begin
            pw_reg <= PW_BUSY;
          end
        end
        PW_BUSY: begin
          if (I_EXEC_DONE) begin
            pw_reg <= PW_AWAKE;
          end
        end
      endcase
    end
  end

  // watchdog: runs while awake, restarts on each start
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      wdt_reg <= 32'h0;
    end else if (pw_reg != PW_AWAKE || start_det) begin
      wdt_reg <= 32'h0;
    end else begin
      wdt_reg <= wdt_reg + 32'h1;
    end
  end

  // bit and byte framing
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      bs_reg <= BS_WAIT;
      bit_reg <= 4'h0;
      sh_reg <= 8'h00;
      ack_reg <= 1'b0;
      slot_reg <= 1'b0;
    end else if (pw_reg != PW_AWAKE && pw_reg != PW_BUSY && pw_reg != PW_WARMUP) begin
      bs_reg <= BS_WAIT;
      bit_reg <= 4'h0;
      ack_reg <= 1'b0;
      slot_reg <= 1'b0;
    end else if (start_det) begin
      bs_reg <= BS_ADDR;
      bit_reg <= 4'h0;
      ack_reg <= 1'b0;
      slot_reg <= 1'b0;
    end else if (stop_det) begin
      bs_reg <= BS_WAIT;
      bit_reg <= 4'h0;
      ack_reg <= 1'b0;
      slot_reg <= 1'b0;
    end else if (bs_reg != BS_WAIT) begin
      if (scl_rise && bit_reg < 4'd8) begin
        sh_reg <= {sh_reg[6:0], sda_sync_reg[1]};
        bit_reg <= bit_reg + 4'h1;
      end else if (scl_fall && bit_reg == 4'd8 && !slot_reg) begin
        // slot flag marks the ack clock, so a nacked byte still ends its frame
        slot_reg <= 1'b1;
        // ack the address only on match, not while executing
        if (bs_reg == BS_ADDR) begin
          ack_reg <= (sh_reg[ADDR_HI_BIT:ADDR_LO_BIT] == I_ADDR_CFG[ADDR_HI_BIT:ADDR_LO_BIT]) &&
                     (pw_reg == PW_AWAKE) && !sh_reg[0];
          if (!((sh_reg[ADDR_HI_BIT:ADDR_LO_BIT] == I_ADDR_CFG[ADDR_HI_BIT:ADDR_LO_BIT]) &&
                (pw_reg == PW_AWAKE) && !sh_reg[0])) begin
            // reads return data outside this block, so they are not claimed here
            bs_reg <= BS_WAIT;
          end
        end else begin
          // nack past the count, and sleep/idle: a release after the ninth rise would be a stop
          ack_reg <= (pw_reg == PW_AWAKE) &&
                     !(bs_reg == BS_DATA && count_reg != 8'h00 && got_reg >= count_reg) &&
                     !(bs_reg == BS_FUNC && (sh_reg == FN_SLEEP || sh_reg == FN_IDLE));
        end
      end else if (scl_fall && bit_reg == 4'd8) begin
        slot_reg <= 1'b0;
        ack_reg <= 1'b0;
        bit_reg <= 4'h0;
        if (bs_reg == BS_ADDR) begin
          bs_reg <= BS_FUNC;
        end else if (bs_reg == BS_FUNC) begin
          bs_reg <= (sh_reg == FN_COMMAND) ? BS_DATA : BS_WAIT;
        end
      end
    end
  end

  // command bytes: first is the count, the rest the block
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      count_reg <= 8'h00;
      got_reg <= 8'h00;
      O_BYTE_VALID <= 1'b0;
      O_BYTE_DATA <= 8'h00;
      O_PTR_RESET <= 1'b0;
      O_CMD_VALID <= 1'b0;
      O_CMD_COUNT <= 8'h00;
    end else begin
      O_BYTE_VALID <= 1'b0;
      O_PTR_RESET <= 1'b0;
      O_CMD_VALID <= 1'b0;
      if (pw_reg == PW_SLEEP || pw_reg == PW_IDLE) begin
        count_reg <= 8'h00;
        got_reg <= 8'h00;
      end else if (pw_reg == PW_AWAKE && full_go && (stop_det || bit_reg == 4'd0)) begin
        O_CMD_VALID <= 1'b1;
        O_CMD_COUNT <= count_reg;
        count_reg <= 8'h00;
        got_reg <= 8'h00;
      end else if (scl_rise && bit_reg == 4'd8 && ack_reg) begin
        if (bs_reg == BS_FUNC && sh_reg == FN_RESET) begin
          O_PTR_RESET <= 1'b1;
          count_reg <= 8'h00;
          got_reg <= 8'h00;
        end else if (bs_reg == BS_DATA && got_reg < 8'(BUF_DEPTH)) begin
          if (got_reg == 8'h00) begin
            count_reg <= sh_reg;
          end
          got_reg <= got_reg + 8'h1;
          O_BYTE_VALID <= 1'b1;
          O_BYTE_DATA <= sh_reg;
        end
      end
    end
  end

  // open drain: only ever pulls low
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_SDA <= 1'b0;
      O_SDA_OE_B <= 1'b1;
    end else begin
      O_SDA <= 1'b0;
      O_SDA_OE_B <= !ack_reg;
    end
  end

  // status outputs; threshold bit fixed per application
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_TTL_EN <= 1'b0;
      O_AWAKE <= 1'b0;
      O_BUSY <= 1'b0;
      O_IDLE_REQ <= 1'b0;
      O_SLEEP_REQ <= 1'b0;
      O_WDT_RESET <= 1'b0;
    end else begin
      O_TTL_EN <= I_ADDR_CFG[TTL_EN_BIT];
      O_AWAKE <= (pw_reg == PW_AWAKE) || (pw_reg == PW_BUSY);
      O_BUSY <= pw_reg == PW_BUSY;
      O_IDLE_REQ <= pw_reg == PW_IDLE;
      O_SLEEP_REQ <= pw_reg == PW_SLEEP;
      O_WDT_RESET <= wdt_reg >= 32'(WATCHDOG_CYCLES);
    end
  end
endmodule
`default_nettype wire
